// ### timer_watchdog_unit.sv
// timer / watchdog top: registers, counter, expiry handling
// What this block does
// R1: reload and count are 16-bit; count is read-only to software
// R2: any clear write clears interrupt, or restarts the watchdog period
// R3: watchdog refresh write reloads the counter every time
// R4: control bit 8 set counts up, clear counts down
// R5: control bit 7 set runs the timer, clear stops it
// R6: control bit 6 set is periodic, clear is free-running
// R7: control bit 5 set enters watchdog mode
// R8: control bits 3:2 divide the tick by 1, 16 or 256; 11 reserved
// R9: control bit 1 set gives irq, clear gives reset at watchdog zero
// R10: control bit 0 set halts counting while peripherals powered down
// R11: software writes zero to control bits 15:9 and 4
// R12: watchdog counts down from reload, holds at zero and acts on the next step at zero
// R13: in watchdog mode reload and control ignore writes until power-on
// R14: counter reloads on overflow when periodic, and at once on a clear write
// R15: counter halts while debug holds the core
// R16: one step per divided tick; normal interrupt held until clear
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module timer_watchdog_unit
  import wdt_pkg::*;
(
  // clock and resets; rstn_in is the power-on reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // ahb-lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic [2:0] hsize_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // 32.768 khz tick, one clk cycle wide
  input wire logic tick_in,
  // system status
  input wire logic periph_powerdown_in,
  input wire logic debug_halt_in,
  // events
  output logic timer_irq_out,
  output logic watchdog_reset_out
);
  logic wr;
  logic rd;
  logic hit;
  logic [1:0] idx;
  logic step;
  logic run;
  bus_req_t unused_req;
  cfg_t cfg_q;
  cfg_t cfg_d;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic irq_q;
  logic irq_d;
  logic wdrst_q;
  logic wdrst_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // hsize unused: only whole-word transfers are expected
  assign unused_req = '{wr: hwrite_in, addr: {hsize_in, 29'h0}};

  wdt_ahb_regs u_regs (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .hsel_in(hsel_in),
    .haddr_in(haddr_in),
    .htrans_in(htrans_in),
    .hwrite_in(hwrite_in),
    .hready_in(hready_in),
    .wr_out(wr),
    .rd_out(rd),
    .idx_out(idx),
    .hit_out(hit)
  );

  // run gating: enable, debug halt and optional power-down halt
  assign run = cfg_q.control[timer_run_bit] // R5
    && !debug_halt_in // R15
    && !(cfg_q.control[powerdown_halt_bit] && periph_powerdown_in); // R10

  wdt_prescaler u_pre (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .tick_in(tick_in),
    .run_in(run),
    .tick_divider_in(cfg_q.control[tick_divider_lsb +: 2]),
    .tick_out(step)
  );

  // configuration and refresh strobe
  always_comb
  begin
    cfg_d = cfg_q;
    cfg_d.refresh = 1'b0;
    if (wr && hit)
    begin
      case (idx)
        2'h0:
        begin
          if (!cfg_q.control[supervise_mode_on_bit]) // R13
            cfg_d.reload = hwdata_in[15:0]; // R1
        end
        2'h2:
        begin
          if (!cfg_q.control[supervise_mode_on_bit]) // R13
            cfg_d.control = hwdata_in[15:0] & timer_control_wmask; // R11
        end
        2'h3: cfg_d.refresh = 1'b1; // R2
        default: ; // count register is not writable R1
      endcase
    end
  end

  // counter, expiry and interrupt
  always_comb
  begin
    logic wdog;
    logic up;
    wdog = cfg_q.control[supervise_mode_on_bit]; // R7
    up = cfg_q.control[count_direction_bit] && !wdog; // R4 R12
    count_d = count_q;
    irq_d = irq_q;
    wdrst_d = wdrst_q;
    if (cfg_q.refresh)
    begin
      count_d = cfg_q.reload; // R3 R14
      if (!wdog)
        irq_d = 1'b0; // R2
    end
    else if (step)
    begin
      if (wdog)
      begin
        if (count_q == 16'h0000)
        begin
          // hold at zero; the expiry event stays until refreshed
          if (cfg_q.control[expiry_irq_select_bit]) // R9
            irq_d = 1'b1; // R12
          else
            wdrst_d = 1'b1; // R12
        end
        else
          count_d = count_q - 16'h0001; // R12 R16
      end
      else if (up)
      begin
        if (count_q == 16'hffff)
        begin
          irq_d = 1'b1; // R16
          count_d = cfg_q.control[periodic_select_bit] ? // R6
            cfg_q.reload : 16'h0000; // R14
        end
        else
          count_d = count_q + 16'h0001; // R4 R16
      end
      else
      begin
        if (count_q == 16'h0000)
        begin
          irq_d = 1'b1; // R16
          count_d = cfg_q.control[periodic_select_bit] ? // R6
            cfg_q.reload : 16'hffff; // R14
        end
        else
          count_d = count_q - 16'h0001; // R4 R16
      end
    end
    // a refresh releases a pending watchdog reset request
    if (cfg_q.refresh && wdog)
    begin
      wdrst_d = 1'b0; // R3
      irq_d = 1'b0;
    end
  end

  // read data, registered into the data phase
  always_comb
  begin
    rdata_d = 32'h00000000;
    if (hsel_in && hready_in && htrans_in == htrans_nonseq && !hwrite_in
        && addr_hit(haddr_in))
    begin
      case (reg_index(haddr_in))
        2'h0: rdata_d = {16'h0000, cfg_q.reload};
        2'h1: rdata_d = {16'h0000, count_d}; // R1
        2'h2: rdata_d = {16'h0000, cfg_q.control};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cfg_q <= '{reload: reload_value_rst, control: timer_control_rst,
                 refresh: 1'b0};
      count_q <= current_count_rst;
      irq_q <= 1'b0;
      wdrst_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      cfg_q <= cfg_d;
      count_q <= count_d;
      irq_q <= irq_d;
      wdrst_q <= wdrst_d;
      rdata_q <= rdata_d;
    end
  end

  assign hrdata_out = rdata_q;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign timer_irq_out = irq_q;
  assign watchdog_reset_out = wdrst_q;
endmodule : timer_watchdog_unit
`default_nettype wire

// ### timer_watchdog_unit_bench.sv
// self-checking bench for the timer / watchdog block
`timescale 1ns/1ps
`default_nettype none
module timer_watchdog_unit_bench
  import wdt_pkg::*;
;
  logic clk_in = 1'b0, rstn = 1'b0, hsel = 1'b0, hwr = 1'b0;
  logic tick = 1'b0, pd = 1'b0, dbg = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdv;
  logic [31:0] seed = 32'h000121a3;
  logic hready, hresp, irq, wrst, mirq, mrst;
  logic [15:0] cnt, rel, ctl;
  int errors = 0, compares = 0;
  int nt[3] = '{32, 256, 16};
  int ns[3] = '{2, 1, 0};
  timer_watchdog_unit i_dut (.clk_in(clk_in), .rstn_in(rstn),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hsize_in(3'h2), .hwrite_in(hwr), .hready_in(hready),
    .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(hresp), .tick_in(tick), .periph_powerdown_in(pd),
    .debug_halt_in(dbg), .timer_irq_out(irq), .watchdog_reset_out(wrst));
  initial forever #2 clk_in = ~clk_in;
  function logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd
  task automatic close_out();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [31:0] a,
    input logic [31:0] d);
    @(posedge clk_in);
    hsel <= 1'b1;
    htrans <= htrans_nonseq;
    haddr <= a;
    hwr <= w;
    do @(posedge clk_in); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_in); while (hready !== 1'b1);
    rdv = hrdata;
  endtask : xfer
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    if (a == reload_value_addr && !ctl[5])
      rel = d[15:0];
    if (a == timer_control_addr && !ctl[5])
      ctl = d[15:0] & timer_control_wmask;
    if (a == clear_refresh_addr)
    begin
      cnt = rel;
      mirq = 1'b0;
      mrst = 1'b0;
    end
    repeat (3) @(posedge clk_in);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rdv, e);
  endtask : rd
  task automatic ev();
    chk({30'h0, irq, wrst}, {30'h0, mirq, mrst});
  endtask : ev
  // model step; watchdog holds at zero and flags on the next step
  function automatic void step();
    if (ctl[5])
    begin
      if (cnt != 16'h0)
        cnt--;
      else if (ctl[1])
        mirq = 1'b1;
      else
        mrst = 1'b1;
    end
    else if (ctl[8] ? cnt == 16'hffff : cnt == 16'h0)
    begin
      cnt = ctl[6] ? rel : (ctl[8] ? 16'h0 : 16'hffff);
      mirq = 1'b1;
    end
    else
      cnt = ctl[8] ? cnt + 16'h1 : cnt - 16'h1;
  endfunction : step
  task automatic tk(input int n);
    repeat (n)
    begin
      @(posedge clk_in);
      tick <= 1'b1;
      @(posedge clk_in);
      tick <= 1'b0;
      repeat (4) @(posedge clk_in);
      if (ctl[7] && ctl[3:2] == 2'h0 && !dbg && !(ctl[0] && pd))
        step();
    end
  endtask : tk
  task automatic por();
    rstn <= 1'b0;
    repeat (6) @(posedge clk_in);
    rstn <= 1'b1;
    cnt = current_count_rst;
    rel = reload_value_rst;
    ctl = timer_control_rst;
    mirq = 1'b0;
    mrst = 1'b0;
  endtask : por
  initial
  begin
    repeat (40000) @(posedge clk_in);
    errors++;
    close_out();
  end
  initial
  begin
    por();
    rd(reload_value_addr, rel);
    rd(timer_control_addr, ctl);
    wr(current_count_addr, 32'h1234);
    rd(current_count_addr, cnt);
    rd(32'hffff0370, 32'h0);
    $display("regs done");
    wr(reload_value_addr, 32'h2);
    wr(timer_control_addr, 32'h0080);
    wr(clear_refresh_addr, rnd());
    tk(3);
    rd(current_count_addr, cnt);
    ev();
    wr(clear_refresh_addr, rnd());
    ev();
    rd(current_count_addr, cnt);
    wr(reload_value_addr, 32'hfffe);
    wr(timer_control_addr, 32'h01c0);
    rd(timer_control_addr, ctl);
    wr(clear_refresh_addr, rnd());
    tk(2);
    rd(current_count_addr, cnt);
    ev();
    // up and free-running wraps to zero
    wr(timer_control_addr, 32'h0180);
    tk(2);
    rd(current_count_addr, cnt);
    // down and periodic reloads at zero
    wr(timer_control_addr, 32'h00c0);
    tk(2);
    rd(current_count_addr, cnt);
    ev();
    wr(timer_control_addr, 32'h0040);
    tk(2);
    rd(current_count_addr, cnt);
    $display("modes done");
    // whole prescaler periods, so the divider phase does not matter
    wr(reload_value_addr, 32'h1000);
    wr(clear_refresh_addr, rnd());
    for (int i = 0; i < 3; i++)
    begin
      wr(timer_control_addr, 32'h0080 | ((i + 1) << tick_divider_lsb));
      tk(nt[i]);
      cnt = cnt - ns[i][15:0];
      rd(current_count_addr, cnt);
    end
    wr(timer_control_addr, 32'h0081);
    pd <= 1'b1;
    tk(2);
    rd(current_count_addr, cnt);
    wr(timer_control_addr, 32'h0080);
    tk(2);
    rd(current_count_addr, cnt);
    pd <= 1'b0;
    dbg <= 1'b1;
    tk(2);
    rd(current_count_addr, cnt);
    dbg <= 1'b0;
    tk(1);
    rd(current_count_addr, cnt);
    $display("halts done");
    wr(reload_value_addr, 32'h2);
    wr(timer_control_addr, 32'h00a2);
    wr(reload_value_addr, 32'h5);
    rd(reload_value_addr, rel);
    wr(timer_control_addr, 32'h0);
    rd(timer_control_addr, ctl);
    wr(clear_refresh_addr, rnd());
    tk(3);
    ev();
    wr(clear_refresh_addr, rnd());
    ev();
    rd(current_count_addr, cnt);
    por();
    wr(reload_value_addr, 32'h1);
    wr(timer_control_addr, 32'h00a0);
    wr(clear_refresh_addr, rnd());
    tk(2);
    ev();
    wr(clear_refresh_addr, rnd());
    ev();
    $display("watchdog done");
    close_out();
  end
endmodule : timer_watchdog_unit_bench
`default_nettype wire

// ### timer_watchdog_unit_props.sv
// checker for the timer / watchdog block ports
`timescale 1ns/1ps
`default_nettype none
module timer_watchdog_unit_props
  import wdt_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // bus
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  // status and events
  input wire logic tick_in,
  input wire logic debug_halt_in,
  input wire logic timer_irq_out,
  input wire logic watchdog_reset_out
);
  logic ap;
  logic ref_ap;
  logic rd_ap;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  assign ap = hsel_in && hready_in && htrans_in == htrans_nonseq;
  assign ref_ap = ap && hwrite_in && haddr_in == clear_refresh_addr;
  assign rd_ap = ap && !hwrite_in;
  // events only drop after a refresh write has landed
  AST_IRQ_HOLD: assert property ($fell(timer_irq_out) |->
    $past(ref_ap, 2) || $past(ref_ap, 3)) else $error("irq dropped");
  AST_RST_HOLD: assert property ($fell(watchdog_reset_out) |->
    $past(ref_ap, 2) || $past(ref_ap, 3)) else $error("reset dropped");
  AST_IRQ_TICK: assert property ($rose(timer_irq_out) |->
    $past(tick_in) || $past(tick_in, 2) || $past(tick_in, 3))
    else $error("irq without tick");
  AST_RST_TICK: assert property ($rose(watchdog_reset_out) |->
    $past(tick_in) || $past(tick_in, 2) || $past(tick_in, 3))
    else $error("reset without tick");
  AST_HALT: assert property (debug_halt_in [*6] |->
    !$rose(timer_irq_out) && !$rose(watchdog_reset_out))
    else $error("event while halted");
  AST_RDATA: assert property (hrdata_out != 32'h0 |-> $past(rd_ap))
    else $error("read data outside read");
  AST_READY: assert property (hreadyout_out)
    else $error("wait state");
  AST_OKAY: assert property (!hresp_out)
    else $error("error response");
endmodule : timer_watchdog_unit_props
bind timer_watchdog_unit timer_watchdog_unit_props i_props (.*);
`default_nettype wire

// ### wdt_ahb_regs.sv
// ahb-lite slave front end: decodes transfers into strobes
`timescale 1ns/1ps
`default_nettype none
module wdt_ahb_regs
  import wdt_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // ahb-lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  // decoded access
  output logic wr_out,
  output logic rd_out,
  output logic [1:0] idx_out,
  output logic hit_out
);
  phase_t ph_q;
  phase_t ph_d;
  logic [31:0] a_q;
  logic [31:0] a_d;

  always_comb
  begin
    ph_d = st_idle;
    a_d = a_q;
    if (hsel_in && hready_in && htrans_in == htrans_nonseq)
    begin
      ph_d = hwrite_in ? st_write : st_read;
      a_d = haddr_in;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ph_q <= st_idle;
      a_q <= 32'h00000000;
    end
    else
    begin
      ph_q <= ph_d;
      a_q <= a_d;
    end
  end

  // data phase: zero wait, so strobes act in the phase itself
  always_comb
  begin
    wr_out = 1'b0;
    rd_out = 1'b0;
    case (ph_q)
      st_write: wr_out = 1'b1;
      st_read: rd_out = 1'b1;
      default: ;
    endcase
  end

  assign idx_out = reg_index(a_q);
  assign hit_out = addr_hit(a_q);
endmodule : wdt_ahb_regs
`default_nettype wire

// ### wdt_pkg.sv
// shared constants and types for the timer / watchdog block
package wdt_pkg;
  localparam logic [31:0] reload_value_addr = 32'hffff0360;
  localparam logic [31:0] current_count_addr = 32'hffff0364;
  localparam logic [31:0] timer_control_addr = 32'hffff0368;
  localparam logic [31:0] clear_refresh_addr = 32'hffff036c;
  localparam logic [15:0] reload_value_rst = 16'h0040;
  localparam logic [15:0] current_count_rst = 16'h0040;
  localparam logic [15:0] timer_control_rst = 16'h0000;
  localparam logic [15:0] timer_control_wmask = 16'h01ef;
  localparam int count_direction_bit = 8;
  localparam int timer_run_bit = 7;
  localparam int periodic_select_bit = 6;
  localparam int supervise_mode_on_bit = 5;
  localparam int tick_divider_lsb = 2;
  localparam int expiry_irq_select_bit = 1;
  localparam int powerdown_halt_bit = 0;
  localparam logic [1:0] div_by_1 = 2'h0;
  localparam logic [1:0] div_by_16 = 2'h1;
  localparam logic [1:0] div_by_256 = 2'h2;
  localparam logic [7:0] div16_mask = 8'h0f;
  localparam logic [7:0] div256_mask = 8'hff;
  localparam logic [1:0] htrans_nonseq = 2'h2;

  typedef struct packed {
    logic wr;
    logic [31:0] addr;
  } bus_req_t;

  typedef struct packed {
    logic [15:0] reload;
    logic [15:0] control;
    logic refresh;
  } cfg_t;

  typedef enum logic [1:0] {
    st_idle,
    st_write,
    st_read
  } phase_t;

  // register select from a byte address
  function automatic logic [1:0] reg_index(input logic [31:0] a);
    reg_index = a[3:2];
  endfunction : reg_index

  function automatic logic addr_hit(input logic [31:0] a);
    addr_hit = (a[31:4] == reload_value_addr[31:4]) && (a[1:0] == 2'h0);
  endfunction : addr_hit
endpackage : wdt_pkg

// ### wdt_prescaler.sv
// prescaler turning the slow tick into a divided count tick
`timescale 1ns/1ps
`default_nettype none
module wdt_prescaler
  import wdt_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // tick in and setting
  input wire logic tick_in,
  input wire logic run_in,
  input wire logic [1:0] tick_divider_in,
  // divided tick
  output logic tick_out
);
  logic [7:0] div_q;
  logic [7:0] div_d;
  logic tick_d;
  logic tick_q;

  always_comb
  begin
    div_d = div_q;
    tick_d = 1'b0;
    if (!run_in)
    begin
      div_d = 8'h00;
    end
    else if (tick_in)
    begin
      div_d = div_q + 8'h01;
      case (tick_divider_in) // R8
        div_by_1: tick_d = 1'b1;
        div_by_16: tick_d = ((div_q & div16_mask) == div16_mask);
        div_by_256: tick_d = (div_q == div256_mask);
        default: tick_d = 1'b0; // reserved code: no ticks
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      div_q <= 8'h00;
      tick_q <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  assign tick_out = tick_q;
endmodule : wdt_prescaler
`default_nettype wire
